// >>> verilog/iaa_defines.svh
// constants for the integer address unit pair
`ifndef IAA_DEFINES_SVH
`define IAA_DEFINES_SVH

// -------------------------------------------------
// status register layout
// -------------------------------------------------
`define FLG_Z 0
`define FLG_N 1
`define FLG_V 2
`define FLG_C 3
`define FLG_RANGE 3:0
`define STAT_IDX 5'h1F
`define STAT_MASK 32'h0000FFFF
`define STAT_KEEP 15:4
`define STAT_RESV 31:16

// -------------------------------------------------
// pipeline timing
// -------------------------------------------------
`define LOAD_LAT 2'h3

// -------------------------------------------------
// circular buffers and quad transfers
// -------------------------------------------------
`define NUM_CB 4
`define SIZE_QUAD 2'h3
`define QUAD_BASE 5'h1C

// -------------------------------------------------
// register bus decode (byte address fields)
// -------------------------------------------------
`define PA_TOP 11:9
`define PA_UNIT 8
`define PA_BANK 7
`define PA_IDX 6:2
`define PA_LANE 1:0
`define BANK_LEN 5'h04
`define BANK_JMP 5'h08

`endif

// >>> verilog/iaa_pkg.sv
// shared types for the integer address unit pair
`default_nettype none
package iaa_pkg;
  // operation codes, arithmetic/logic/function group first
  typedef enum logic [4:0] {
    OP_ADD, OP_ADDC, OP_SUB, OP_SUBC, OP_AVG, OP_ASHR, OP_LSHR, OP_ROT,
    OP_AND, OP_ANDN, OP_NOT, OP_OR, OP_XOR, OP_ABS, OP_MIN, OP_MAX,
    OP_COMP, OP_MOVE, OP_LOAD, OP_STORE
  } op_t;

  // instruction options
  typedef struct packed {
    logic wrap_option;
    logic reverse_carry_option;
    logic jump_option;
    logic keep_flags_option;
    logic uns;
  } opt_t;

  // one instruction slot for one unit
  typedef struct packed {
    logic valid;
    op_t op;
    opt_t opt;
    logic [4:0] dst;
    logic [4:0] srca;
    logic [4:0] srcb;
    logic use_imm;
    logic [31:0] imm;
    logic [1:0] size;
  } req_t;

  // memory request of one unit
  typedef struct packed {
    logic [31:0] addr;
    logic rd;
    logic wr;
    logic [1:0] size;
    logic [3:0][31:0] wdata;
  } mem_t;

  // all state of one unit
  typedef struct packed {
    logic [31:0][31:0] regs;
    logic [3:0][31:0] base;
    logic [3:0][31:0] len;
    logic ready;
    logic [1:0] cnt;
    logic [4:0] pdst;
    logic [1:0] psize;
    logic [31:0] res;
    mem_t mem;
  } unit_t;

  // all state of the pair
  typedef struct packed {
    unit_t [1:0] u;
    logic [31:0] jt;
    logic jv;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } state_t;

  // arithmetic, logic and function group
  function automatic logic is_alu(input op_t op);
    return op <= OP_COMP;
  endfunction

  // add and subtract family
  function automatic logic is_addsub(input op_t op);
    return op inside {OP_ADD, OP_ADDC, OP_SUB, OP_SUBC};
  endfunction
endpackage
`default_nettype wire

// >>> verilog/iaa_int_alu.sv
// combinational integer datapath of one unit
`timescale 1ns/1ns
`default_nettype none
`include "iaa_defines.svh"
module iaa_int_alu (
  // operation
  input wire iaa_pkg::op_t i_op,
  input wire iaa_pkg::opt_t i_opt,
  input wire logic i_cin,
  // operands and buffer bounds
  input wire logic [31:0] i_a,
  input wire logic [31:0] i_b,
  input wire logic [31:0] i_base,
  input wire logic [31:0] i_len,
  // result and flags
  output logic [31:0] o_res,
  output logic [3:0] o_flags
);
  // bit order reversal
  function automatic logic [31:0] rev(input logic [31:0] v);
    for (int k = 0; k < 32; k++) rev[k] = v[31-k];
  endfunction

  logic sub;          // subtract family
  logic c0;           // carry into the adder
  logic [31:0] bx;    // possibly inverted b
  logic [32:0] sum;   // adder with carry out
  logic [32:0] avg;   // sign-extended sum
  logic [63:0] rot;   // rotate scratch
  logic [31:0] top;   // end of circular buffer

  // --------------------------------------------------------
  // operation select
  // --------------------------------------------------------
  always_comb begin
    sub = i_op inside {iaa_pkg::OP_SUB, iaa_pkg::OP_SUBC, iaa_pkg::OP_COMP};
    c0 = (i_op == iaa_pkg::OP_ADDC || i_op == iaa_pkg::OP_SUBC) ? i_cin : sub;
    bx = sub ? ~i_b : i_b;
    sum = {1'b0, i_a} + {1'b0, bx} + {32'h0, c0};
    avg = {i_a[31], i_a} + {i_b[31], i_b};
    rot = {i_a, i_a} >> i_b[4:0];
    top = i_base + i_len;
    o_res = sum[31:0];
    o_flags = 4'h0;
    o_flags[`FLG_C] = iaa_pkg::is_addsub(i_op) & sum[32];
    o_flags[`FLG_V] = iaa_pkg::is_addsub(i_op) & (i_a[31] == bx[31]) & (sum[31] != i_a[31]);
    unique case (i_op)
      iaa_pkg::OP_ADD, iaa_pkg::OP_ADDC, iaa_pkg::OP_SUB, iaa_pkg::OP_SUBC: begin
        if (i_opt.wrap_option) begin
          if (!sub && sum[31:0] >= top) o_res = sum[31:0] - i_len;
          if (sub && sum[31:0] < i_base) o_res = sum[31:0] + i_len;
        end else if (i_opt.reverse_carry_option && !sub) begin
          o_res = rev(rev(i_a) + rev(i_b));
          o_flags[`FLG_C] = 1'b0;
          o_flags[`FLG_V] = 1'b0;
        end
      end
      iaa_pkg::OP_AVG: o_res = avg[32:1];
      iaa_pkg::OP_ASHR: o_res = $signed(i_a) >>> i_b[4:0];
      iaa_pkg::OP_LSHR: o_res = i_a >> i_b[4:0];
      iaa_pkg::OP_ROT: o_res = rot[31:0];
      iaa_pkg::OP_AND: o_res = i_a & i_b;
      iaa_pkg::OP_ANDN: o_res = i_a & ~i_b;
      iaa_pkg::OP_NOT: o_res = ~i_a;
      iaa_pkg::OP_OR: o_res = i_a | i_b;
      iaa_pkg::OP_XOR: o_res = i_a ^ i_b;
      iaa_pkg::OP_ABS: begin
        o_res = i_a[31] ? -i_a : i_a;
        o_flags[`FLG_V] = i_a[31] & (o_res[31]);
      end
      iaa_pkg::OP_MIN: o_res = ($signed(i_a) < $signed(i_b)) ? i_a : i_b;
      iaa_pkg::OP_MAX: o_res = ($signed(i_a) > $signed(i_b)) ? i_a : i_b;
      iaa_pkg::OP_COMP: o_res = sum[31:0];
      default: o_res = sum[31:0];
    endcase
    o_flags[`FLG_Z] = (o_res == 32'h0);
    o_flags[`FLG_N] = o_res[31];
    if (i_op == iaa_pkg::OP_ABS) o_flags[`FLG_N] = i_a[31];
    if (i_op == iaa_pkg::OP_COMP) begin
      o_flags[`FLG_N] = i_opt.uns ? (i_a < i_b) : ($signed(i_a) < $signed(i_b));
      o_flags[`FLG_C] = 1'b0;
      o_flags[`FLG_V] = 1'b0;
    end
  end
endmodule // iaa_int_alu
`default_nettype wire

// >>> verilog/integer_address_alu_pair.sv
// pair of integer address units with register bus access
`timescale 1ns/1ns
`default_nettype none
`include "iaa_defines.svh"

module integer_address_alu_pair (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rstn,
  // register bus
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // instruction slots, one per unit
  input wire iaa_pkg::req_t [1:0] i_req,
  output logic [1:0] o_ready,
  output logic [1:0][31:0] o_result,
  // memory side, one per unit
  output iaa_pkg::mem_t [1:0] o_mem,
  input wire logic [1:0][3:0][31:0] i_rdata,
  // sequencer jump target
  output logic [31:0] o_jump_target,
  output logic o_jump_valid
);
  // --------------------------------------------------------
  // helpers
  // --------------------------------------------------------
  // entry 31 is status
  // source operand, status entry reads as zero
  function automatic logic [31:0] opnd(input logic [31:0][31:0] rf,
                                       input logic [4:0] i);
    return (i == `STAT_IDX) ? 32'h0 : rf[i];
  endfunction

  // write value, reserved status bits forced low
  function automatic logic [31:0] wmask(input logic [4:0] i,
                                        input logic [31:0] v);
    return (i == `STAT_IDX) ? (v & `STAT_MASK) : v;
  endfunction

  iaa_pkg::state_t st_q;           // all state
  iaa_pkg::state_t st_d;           // its next value
  iaa_pkg::opt_t [1:0] eopt;       // options after arbitration
  logic [1:0] acc;                 // instruction taken
  logic [1:0][31:0] aop;           // first operand
  logic [1:0][31:0] bop;           // second operand
  logic [1:0][31:0] ares;          // datapath result
  logic [1:0][3:0] afl;            // datapath flags
  logic unit;                      // bus unit select
  logic bank;                      // bus bank select
  logic [4:0] idx;                 // bus register index
  logic bad;                       // unmapped bus address or jump target write
  logic apb_wr;                    // bus write completes
  logic [31:0] rdv;                // bus read value

  // --------------------------------------------------------
  // per-unit operand fetch and datapath
  // --------------------------------------------------------
  // two identical units
  for (genvar g = 0; g < 2; g++) begin : g_unit
    assign acc[g] = i_req[g].valid & st_q.u[g].ready;
    assign aop[g] = opnd(st_q.u[g].regs, i_req[g].srca);
    assign bop[g] = i_req[g].use_imm ? i_req[g].imm : opnd(st_q.u[g].regs, i_req[g].srcb);
    assign eopt[g].wrap_option = i_req[g].opt.wrap_option & (i_req[g].srca < 5'(`NUM_CB));
    assign eopt[g].reverse_carry_option = i_req[g].opt.reverse_carry_option
                                          & ~i_req[g].opt.wrap_option;
    assign eopt[g].jump_option = i_req[g].opt.jump_option & ~i_req[g].opt.wrap_option
                                 & ~i_req[g].opt.reverse_carry_option
                                 & iaa_pkg::is_addsub(i_req[g].op);
    assign eopt[g].keep_flags_option = i_req[g].opt.keep_flags_option;
    assign eopt[g].uns = i_req[g].opt.uns;

    iaa_int_alu u_alu (
      .i_op(i_req[g].op),
      .i_opt(eopt[g]),
      .i_cin(st_q.u[g].regs[`STAT_IDX][`FLG_C]),
      .i_a(aop[g]),
      .i_b(bop[g]),
      // buffer n uses base n, length n
      .i_base(st_q.u[g].base[i_req[g].srca[1:0]]),
      .i_len(st_q.u[g].len[i_req[g].srca[1:0]]),
      .o_res(ares[g]),
      .o_flags(afl[g])
    );
  end

  // --------------------------------------------------------
  // register bus decode
  // --------------------------------------------------------
  assign unit = i_paddr[`PA_UNIT];
  assign bank = i_paddr[`PA_BANK];
  assign idx = i_paddr[`PA_IDX];
  assign bad = (|i_paddr[`PA_TOP]) | (|i_paddr[`PA_LANE]) | (bank & (idx > `BANK_JMP))
               | (bank & (idx == `BANK_JMP) & i_pwrite);
  assign apb_wr = i_psel & i_penable & st_q.pready & ~st_q.pslverr & i_pwrite;
  assign rdv = !bank ? st_q.u[unit].regs[idx] :
               (idx == `BANK_JMP) ? st_q.jt :
               (idx < `BANK_LEN) ? st_q.u[unit].base[idx[1:0]] :
               st_q.u[unit].len[idx[1:0]];

  // --------------------------------------------------------
  // next state
  // --------------------------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.jv = 1'b0;
    for (int u = 0; u < 2; u++) begin
      st_d.u[u].mem.rd = 1'b0;
      st_d.u[u].mem.wr = 1'b0;
      if (st_q.u[u].cnt != 2'h0) begin
        st_d.u[u].cnt = st_q.u[u].cnt - 2'h1;
        // load data lands on the last stall cycle
        if (st_q.u[u].cnt == 2'h1) begin
          for (int k = 0; k < 4; k++) begin
            if (2'(k) <= st_q.u[u].psize) begin
              st_d.u[u].regs[st_q.u[u].pdst + 5'(k)] =
                wmask(st_q.u[u].pdst + 5'(k), i_rdata[u][k]);
            end
          end
        end
      end
      if (acc[u]) begin
        if (iaa_pkg::is_alu(i_req[u].op)) begin
          st_d.u[u].res = ares[u];
          if (i_req[u].op != iaa_pkg::OP_COMP && i_req[u].dst != `STAT_IDX) begin
            st_d.u[u].regs[i_req[u].dst] = ares[u];
          end
          if (!i_req[u].opt.keep_flags_option) begin
            st_d.u[u].regs[`STAT_IDX][`FLG_RANGE] = afl[u];
          end
          if (eopt[u].jump_option) begin
            st_d.jt = ares[u];
            st_d.jv = 1'b1;
          end
        end else if (i_req[u].op == iaa_pkg::OP_MOVE) begin
          st_d.u[u].regs[i_req[u].dst] = wmask(i_req[u].dst,
            i_req[u].use_imm ? i_req[u].imm : st_q.u[u].regs[i_req[u].srca]);
        end else begin
          // one address per unit per cycle
          st_d.u[u].mem.addr = aop[u] + bop[u];
          st_d.u[u].mem.size = i_req[u].size;
          st_d.u[u].mem.wdata = '0;
          if (i_req[u].op == iaa_pkg::OP_LOAD) begin
            st_d.u[u].mem.rd = 1'b1;
            st_d.u[u].cnt = `LOAD_LAT;
            st_d.u[u].pdst = i_req[u].dst & ~{3'h0, i_req[u].size};
            st_d.u[u].psize = i_req[u].size;
          end else begin
            st_d.u[u].mem.wr = 1'b1;
            for (int k = 0; k < 4; k++) begin
              if (2'(k) <= i_req[u].size) begin
                st_d.u[u].mem.wdata[k] = st_q.u[u].regs[(i_req[u].dst
                  & ~{3'h0, i_req[u].size}) + 5'(k)];
              end
            end
          end
        end
      end
      st_d.u[u].ready = (st_d.u[u].cnt == 2'h0);
    end
    // bus setup phase latches answer, access phase completes
    st_d.pready = i_psel & ~i_penable;
    if (i_psel && !i_penable) begin
      st_d.pslverr = bad;
      st_d.prdata = bad ? 32'h0 : rdv;
    end
    // bus write wins over a same-cycle unit update
    if (apb_wr) begin
      if (!bank) begin
        st_d.u[unit].regs[idx] = wmask(idx, i_pwdata);
      end else if (idx < `BANK_LEN) begin
        st_d.u[unit].base[idx[1:0]] = i_pwdata;
      end else begin
        st_d.u[unit].len[idx[1:0]] = i_pwdata;
      end
    end
  end

  // --------------------------------------------------------
  // state register
  // --------------------------------------------------------
  // register files and buffer registers
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // --------------------------------------------------------
  // outputs straight from state
  // --------------------------------------------------------
  assign o_prdata = st_q.prdata;
  assign o_pready = st_q.pready;
  assign o_pslverr = st_q.pslverr;
  assign o_jump_target = st_q.jt;
  assign o_jump_valid = st_q.jv;
  for (genvar g = 0; g < 2; g++) begin : g_out
    assign o_ready[g] = st_q.u[g].ready;
    assign o_result[g] = st_q.u[g].res;
    assign o_mem[g] = st_q.u[g].mem;
  end

  // --------------------------------------------------------
  // checks
  // --------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);

  for (genvar g = 0; g < 2; g++) begin : g_chk
    logic alu_g;   // compute op taken
    logic quiet_g; // no bus write alongside
    assign alu_g = acc[g] & iaa_pkg::is_alu(i_req[g].op);
    assign quiet_g = ~apb_wr;

    sequence s_load_take;
      acc[g] && i_req[g].op == iaa_pkg::OP_LOAD;
    endsequence
    sequence s_stall;
      !o_ready[g] [*3] ##1 o_ready[g];
    endsequence

    a_load_stall: assert property (s_load_take |=> s_stall)
      else $error("load interlock length wrong");
    a_alu_rate: assert property (alu_g |=> o_ready[g])
      else $error("compute op stalled the unit");
    a_result_write: assert property (alu_g && quiet_g
      && i_req[g].op != iaa_pkg::OP_COMP && i_req[g].dst != `STAT_IDX
      |=> st_q.u[g].regs[$past(i_req[g].dst)] == o_result[g])
      else $error("result not in destination");
    a_dst_status: assert property (alu_g && quiet_g && i_req[g].dst == `STAT_IDX
      |=> $stable(st_q.u[g].regs[`STAT_IDX][`STAT_KEEP]))
      else $error("status overwritten by result");
    a_stat_resv: assert property (st_q.u[g].regs[`STAT_IDX][`STAT_RESV] == 16'h0)
      else $error("reserved status bits set");
    a_flag_keep: assert property (alu_g && quiet_g && i_req[g].opt.keep_flags_option
      |=> $stable(st_q.u[g].regs[`STAT_IDX][`FLG_RANGE]))
      else $error("flags changed under keep option");
    a_logic_cv: assert property (acc[g] && quiet_g
      && !i_req[g].opt.keep_flags_option
      && i_req[g].op inside {iaa_pkg::OP_AND, iaa_pkg::OP_ANDN, iaa_pkg::OP_NOT,
      iaa_pkg::OP_OR, iaa_pkg::OP_XOR}
      |=> st_q.u[g].regs[`STAT_IDX][`FLG_C] == 1'b0
      && st_q.u[g].regs[`STAT_IDX][`FLG_V] == 1'b0)
      else $error("logic op left carry or overflow");
    a_neg_flag: assert property (alu_g && quiet_g
      && !i_req[g].opt.keep_flags_option
      && !(i_req[g].op inside {iaa_pkg::OP_ABS, iaa_pkg::OP_COMP})
      |=> st_q.u[g].regs[`STAT_IDX][`FLG_N] == o_result[g][31])
      else $error("negative flag disagrees with result");
    a_jump_copy: assert property (acc[g] && eopt[g].jump_option
      && (g == 1 || !(acc[1] && eopt[1].jump_option))
      |=> o_jump_valid && o_jump_target == o_result[g])
      else $error("jump target not loaded");

    a_zero_flag: assert property (alu_g && quiet_g
      && !i_req[g].opt.keep_flags_option
      |=> st_q.u[g].regs[`STAT_IDX][`FLG_Z] == (o_result[g] == 32'h0))
      else $error("zero flag disagrees with result");

    // carry only from add and subtract
    a_carry_clr: assert property (alu_g && quiet_g
      && !i_req[g].opt.keep_flags_option && !iaa_pkg::is_addsub(i_req[g].op)
      |=> st_q.u[g].regs[`STAT_IDX][`FLG_C] == 1'b0)
      else $error("carry set by an op other than add or subtract");

    // one read strobe per load, one cycle wide
    sequence s_rd_pulse;
      o_mem[g].rd ##1 !o_mem[g].rd;
    endsequence
    a_load_req: assert property (s_load_take |=> s_rd_pulse)
      else $error("load request strobe wrong");

    a_move_stat: assert property (acc[g] && quiet_g
      && i_req[g].op == iaa_pkg::OP_MOVE && !i_req[g].use_imm
      && i_req[g].srca == `STAT_IDX && i_req[g].dst != `STAT_IDX
      |=> st_q.u[g].regs[$past(i_req[g].dst)] == $past(st_q.u[g].regs[`STAT_IDX]))
      else $error("move lost status contents");

    // quad load fills status from word three
    a_quad_stat: assert property (st_q.u[g].cnt == 2'h1 && quiet_g
      && st_q.u[g].psize == `SIZE_QUAD && st_q.u[g].pdst == `QUAD_BASE
      |=> st_q.u[g].regs[`STAT_IDX] == ($past(i_rdata[g][3]) & `STAT_MASK))
      else $error("quad load missed status");
  end
endmodule // integer_address_alu_pair
`default_nettype wire

// >>> verif/mem_model.sv
// memory stand-in answering the load requests of both units
`timescale 1ns/1ns
`default_nettype none
module mem_model (
  // clock
  input wire logic i_mclk,
  // requests from both units
  input wire iaa_pkg::mem_t [1:0] i_mem,
  // load data back to the units
  output logic [1:0][3:0][31:0] o_rdata
);
  // cycles left during which load data stays valid
  logic [1:0][1:0] hold_q;

  initial begin
    o_rdata = '0;
    hold_q = '0;
  end

  // answer each read, then scramble the bus so stale data never matches
  always @(posedge i_mclk) begin
    for (int u = 0; u < 2; u++) begin
      if (i_mem[u].rd) begin
        for (int k = 0; k < 4; k++) begin
          o_rdata[u][k] <= i_mem[u].addr ^ (32'hA5000000 * (k + 1));
        end
        hold_q[u] <= 2'h2;
      end else if (hold_q[u] != 2'h0) begin
        hold_q[u] <= hold_q[u] - 2'h1;
      end else begin
        o_rdata[u] <= ~o_rdata[u];
      end
    end
  end
endmodule // mem_model
`default_nettype wire

// >>> verif/tb_top.sv
// self-checking testbench of the integer address unit pair
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  // ---------------------------------
  // signals
  // ---------------------------------
  logic mclk, rst_n, psel, penable, pwrite, pready, pslverr, jmp_v;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, jmp_t, rdv, a, b, ad;
  logic [35:0] ex;
  logic [1:0] ready;
  logic [1:0][31:0] result;
  logic [1:0][3:0][31:0] rdata;
  logic err;
  iaa_pkg::req_t [1:0] req;
  iaa_pkg::mem_t [1:0] mem_req;
  iaa_pkg::opt_t op_o;
  iaa_pkg::op_t tbl [6] = '{iaa_pkg::OP_ADD, iaa_pkg::OP_SUB, iaa_pkg::OP_AND,
    iaa_pkg::OP_ANDN, iaa_pkg::OP_OR, iaa_pkg::OP_XOR};
  integer seed = 32'hDFFB1542; // fixed seed keeps runs repeatable
  int mismatches, samples_checked, cycles, u, cnt;

  integer_address_alu_pair u_dut (.i_mclk(mclk), .i_rstn(rst_n), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_req(req),
    .o_ready(ready), .o_result(result), .o_mem(mem_req), .i_rdata(rdata),
    .o_jump_target(jmp_t), .o_jump_valid(jmp_v));
  mem_model u_mem (.i_mclk(mclk), .i_mem(mem_req), .o_rdata(rdata));

  // ---------------------------------
  // checking and bus tasks
  // ---------------------------------
  task chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  // apb transfer: setup, then access until pready is sampled high
  task apb(input logic w, input int un, bk, idx, input logic [31:0] wd);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {3'h0, un[0], bk[0], idx[4:0], 2'h0};
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // issue one instruction to unit un and wait until it is taken
  task exec(input int un, input iaa_pkg::op_t op, input logic [4:0] d, sa, sb,
            input logic ui, input logic [31:0] im, input logic [1:0] sz);
    iaa_pkg::req_t r;
    r = '0;
    r.valid = 1'b1;
    r.op = op;
    r.opt = op_o;
    r.dst = d;
    r.srca = sa;
    r.srcb = sb;
    r.use_imm = ui;
    r.imm = im;
    r.size = sz;
    @(posedge mclk);
    req[un] <= r;
    do @(posedge mclk); while (ready[un] !== 1'b1);
    req[un].valid <= 1'b0;
    #1;
  endtask

  // expected {carry, overflow, negative, zero, result}
  function automatic logic [35:0] ref_op(input iaa_pkg::op_t op, input logic [31:0] x, y);
    logic [32:0] s;
    logic v, c;
    v = 1'b0;
    c = 1'b0;
    s = '0;
    case (op)
      iaa_pkg::OP_ADD: begin
        s = {1'b0, x} + {1'b0, y};
        c = s[32];
        v = (x[31] == y[31]) && (s[31] != x[31]);
      end
      iaa_pkg::OP_SUB: begin
        s[31:0] = x - y;
        c = (x >= y);
        v = (x[31] != y[31]) && (s[31] != x[31]);
      end
      iaa_pkg::OP_AND: s[31:0] = x & y;
      iaa_pkg::OP_OR: s[31:0] = x | y;
      iaa_pkg::OP_XOR: s[31:0] = x ^ y;
      default: s[31:0] = x & ~y;
    endcase
    return {c, v, s[31], s[31:0] == 32'h0, s[31:0]};
  endfunction

  task end_sim;
    $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ---------------------------------
  // clock, reset and timeout
  // ---------------------------------
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // cut a hang short
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      end_sim();
    end
  end

  // ---------------------------------
  // main sequence
  // ---------------------------------
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    req = '0;
    op_o = '0;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    // register map, reserved status bits, refused accesses
    for (u = 0; u < 2; u++) begin
      apb(1'b1, u, 0, 31, 32'hFFFFFFFF);
      apb(1'b0, u, 0, 31, 32'h0);
      chk_word("status", 32'h0000FFFF, rdv);
      apb(1'b1, u, 0, 31, 32'h0);
      a = $random(seed);
      apb(1'b1, u, 1, 6, a);
      apb(1'b0, u, 1, 6, 32'h0);
      chk_word("length reg", a, rdv);
    end
    apb(1'b1, 0, 1, 8, 32'h1234);
    chk_word("jump write err", 32'h1, {31'h0, err});
    $display("test registers done");
    // random compute ops on both units
    for (int n = 0; n < 24; n++) begin
      u = $random(seed) & 1;
      a = (n == 0) ? 32'h7FFFFFFF : $random(seed);
      b = (n == 0) ? 32'h00000001 : $random(seed);
      apb(1'b1, u, 0, 1, a);
      apb(1'b1, u, 0, 2, b);
      ex = ref_op(tbl[n % 6], a, b);
      exec(u, tbl[n % 6], 5'h3, 5'h1, 5'h2, 1'b0, 32'h0, 2'h0);
      chk_word("result", ex[31:0], result[u]);
      apb(1'b0, u, 0, 31, 32'h0);
      chk_word("flags", {28'h0, ex[35:32]}, rdv);
      apb(1'b0, u, 0, 3, 32'h0);
      chk_word("dest reg", ex[31:0], rdv);
    end
    $display("test compute done");
    // entry 31 as source and destination, then kept flags
    apb(1'b1, 1, 0, 2, 32'h80000000);
    ex = ref_op(iaa_pkg::OP_ADD, 32'h0, 32'h80000000);
    exec(1, iaa_pkg::OP_ADD, 5'h1F, 5'h1F, 5'h2, 1'b0, 32'h0, 2'h0);
    chk_word("zero entry sum", ex[31:0], result[1]);
    apb(1'b0, 1, 0, 31, 32'h0);
    chk_word("discarded dest", {28'h0, ex[35:32]}, rdv);
    op_o.keep_flags_option = 1'b1;
    exec(1, iaa_pkg::OP_ADD, 5'h5, 5'h1F, 5'h1F, 1'b0, 32'h0, 2'h0);
    op_o = '0;
    apb(1'b0, 1, 0, 31, 32'h0);
    chk_word("kept flags", {28'h0, ex[35:32]}, rdv);
    // computed jump on the first unit, pulse looked at while it stands
    a = $random(seed);
    apb(1'b1, 0, 0, 2, a);
    op_o.jump_option = 1'b1;
    exec(0, iaa_pkg::OP_ADD, 5'h4, 5'h1F, 5'h2, 1'b0, 32'h0, 2'h0);
    op_o = '0;
    chk_word("jump pulse", 32'h1, {31'h0, jmp_v});
    chk_word("jump target", a, jmp_t);
    apb(1'b0, 0, 0, 4, 32'h0);
    chk_word("jump dest", a, rdv);
    $display("test options done");
    // circular wrap, reversed carry, average, move and unsigned compare
    apb(1'b1, 1, 1, 0, 32'h100);
    apb(1'b1, 1, 1, 4, 32'h40);
    apb(1'b1, 1, 0, 0, 32'h130);
    op_o.wrap_option = 1'b1;
    exec(1, iaa_pkg::OP_ADD, 5'h5, 5'h0, 5'h0, 1'b1, 32'h20, 2'h0);
    chk_word("wrap add", 32'h110, result[1]);
    exec(1, iaa_pkg::OP_SUB, 5'h5, 5'h0, 5'h0, 1'b1, 32'h38, 2'h0);
    chk_word("wrap sub", 32'h138, result[1]);
    op_o = '0;
    apb(1'b0, 1, 0, 0, 32'h0);
    chk_word("wrap index", 32'h130, rdv);
    apb(1'b1, 1, 0, 1, 32'h80000000);
    op_o.reverse_carry_option = 1'b1;
    exec(1, iaa_pkg::OP_ADD, 5'h6, 5'h1, 5'h0, 1'b1, 32'h80000000, 2'h0);
    op_o = '0;
    chk_word("reverse add", 32'h40000000, result[1]);
    exec(1, iaa_pkg::OP_AVG, 5'h6, 5'h1, 5'h0, 1'b1, 32'h0, 2'h0);
    chk_word("average", 32'hC0000000, result[1]);
    exec(1, iaa_pkg::OP_MOVE, 5'h7, 5'h1F, 5'h0, 1'b0, 32'h0, 2'h0);
    apb(1'b0, 1, 0, 7, 32'h0);
    chk_word("status move", 32'h2, rdv);
    op_o.uns = 1'b1;
    exec(1, iaa_pkg::OP_COMP, 5'h6, 5'h1, 5'h0, 1'b1, 32'h1, 2'h0);
    op_o = '0;
    apb(1'b0, 1, 0, 31, 32'h0);
    chk_word("unsigned compare", 32'h0, rdv);
    $display("test address options done");
    // quad load into entries 28..31 with stall count
    for (u = 0; u < 2; u++) begin
      ad = $random(seed) & 32'hFFFFFFF0;
      exec(u, iaa_pkg::OP_LOAD, 5'h1C, 5'h1F, 5'h0, 1'b1, ad, 2'h3);
      chk_word("load addr", ad, mem_req[u].addr);
      cnt = 0;
      while (ready[u] !== 1'b1 && cnt < 9) begin
        @(posedge mclk);
        #1;
        cnt++;
      end
      chk_word("stall cycles", 32'h3, cnt);
      apb(1'b0, u, 0, 28, 32'h0);
      chk_word("quad word0", ad ^ 32'hA5000000, rdv);
      apb(1'b0, u, 0, 31, 32'h0);
      chk_word("quad status", (ad ^ (32'hA5000000 * 4)) & 32'h0000FFFF, rdv);
    end
    $display("test loads done");
    end_sim();
  end
endmodule // tb_top
`default_nettype wire
